// ---- hw/epaper_cmd_status_partial_otp.sv ----
// command decoder: status, vcom measurement, partial window, otp, cascade, saving
// assumes host on the three-wire link; analog and sensor logic share clk
`timescale 1ns/10ps
`include "epaper_cmd_defs.svh"
module epaper_cmd_status_partial_otp
    import epaper_cmd_pkg::*;
#(
    parameter int unsigned MEAS0_CYC = `MEAS_T0_S * `CLK_HZ,
    parameter int unsigned MEAS1_CYC = `MEAS_T1_S * `CLK_HZ,
    parameter int unsigned MEAS2_CYC = `MEAS_T2_S * `CLK_HZ,
    parameter int unsigned MEAS3_CYC = `MEAS_T3_S * `CLK_HZ,
    parameter int unsigned PROG_CYC = `PROG_DEFAULT_CYC,
    parameter int OTP_AW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link pins
    input wire logic csb_n,
    input wire logic sclk,
    input wire logic sda_in,
    input wire logic dc,
    output logic sda_out,
    output logic sda_oe,
    output logic busy_n,
    // status from surrounding logic
    input wire logic sensor_master_error,
    input wire logic sensor_master_idle_n,
    input wire logic frame_received,
    input wire logic powered_on_flag,
    input wire logic powered_off_flag,
    input wire logic [5:0] measured_code_in,
    input wire logic [7:0] sensor_temperature,
    input wire logic polarity_reversal,
    input wire logic line_tick,
    // measurement
    output logic measure_active,
    output logic all_gates_on,
    output logic measure_source_level,
    output logic measure_result_path,
    output logic [5:0] measured_vcom_code,
    output logic [5:0] vcom_dc_code,
    // partial window
    output logic partial_active_flag,
    output logic [5:0] horiz_window_start,
    output logic [5:0] horiz_window_end,
    output logic [8:0] vert_window_start,
    output logic [8:0] vert_window_end,
    output logic window_scan_option,
    // otp
    output logic program_mode,
    // cascade, temperature, saving, supply
    output logic cascade_clock_pin,
    output logic fixed_temperature_select,
    output logic [7:0] temperature_value,
    output logic [3:0] vcom_saving_width,
    output logic [3:0] source_saving_width,
    output logic vcom_saving_active,
    output logic source_saving_active,
    output logic [1:0] low_supply_threshold,
    output logic supply_or_break_select
);
    cmd_state_e state_reg;
    byte_t cmd_reg;
    byte_t meas_param_reg;
    byte_t tx_data_reg;
    logic [3:0] idx_reg;
    logic tx_load_reg;
    logic [OTP_AW-1:0] rd_addr_reg;
    logic [OTP_AW-1:0] wr_addr_reg;
    logic [7:0] otp_mem [0:(1<<OTP_AW)-1];
    logic cascade_en_reg;
    logic cascade_div_reg;
    logic meas_busy_d_reg;
    logic rx_valid;
    logic rx_is_data;
    logic tx_next;
    byte_t rx_byte;
    logic cmd_start;
    logic par_wr;
    logic meas_start;
    logic prog_start;
    logic meas_busy;
    logic prog_busy;
    logic [31:0] meas_load;
    byte_t flag_byte;
    byte_t first_byte;
    byte_t forced_temp_reg;

    function automatic logic is_read(input byte_t op);
        is_read = (op == `OP_REVISION) || (op == `OP_FLAGS) ||
            (op == `OP_VCOM_VALUE) || (op == `OP_OTP_READ);
    endfunction

    // ****************************************
    // link and command framing
    // ****************************************
    spi3_byte_link u_link (
        .clk(clk),
        .rst_n(rst_n),
        .csb_n(csb_n),
        .sclk(sclk),
        .sda_in(sda_in),
        .dc(dc),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .tx_mode(state_reg == ST_READ),
        .tx_load(tx_load_reg),
        .tx_byte(tx_data_reg),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .rx_is_data(rx_is_data),
        .tx_next(tx_next)
    );

    assign cmd_start = rx_valid & ~rx_is_data; // R23
    assign par_wr = rx_valid & rx_is_data & (state_reg == ST_PARAM);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
            cmd_reg <= 8'h00;
            idx_reg <= 4'h0;
        end
        else if (cmd_start)
        begin
            cmd_reg <= rx_byte;
            idx_reg <= 4'h0;
            state_reg <= is_read(rx_byte) ? ST_READ : ST_PARAM; // R23
        end
        else if (par_wr && idx_reg != 4'hF)
            idx_reg <= idx_reg + 4'h1;
    end

    // ****************************************
    // read answers
    // ****************************************
    assign flag_byte = {1'b0, partial_active_flag, sensor_master_error, sensor_master_idle_n,
        frame_received, powered_on_flag, powered_off_flag, busy_n}; // R2

    always_comb
    begin
        case (rx_byte)
            `OP_REVISION: first_byte = otp_mem[`REV_ADDR]; // R1
            `OP_FLAGS: first_byte = flag_byte; // R2
            `OP_VCOM_VALUE: first_byte = {2'b00, measured_vcom_code}; // R8
            default: first_byte = 8'h00; // R17
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_load_reg <= 1'b0;
            tx_data_reg <= 8'h00;
            rd_addr_reg <= '0;
        end
        else
        begin
            tx_load_reg <= (cmd_start && is_read(rx_byte)) || (tx_next && state_reg == ST_READ);
            if (cmd_start)
            begin
                tx_data_reg <= first_byte;
                rd_addr_reg <= '0;
            end
            else if (tx_next && cmd_reg == `OP_OTP_READ)
            begin
                tx_data_reg <= otp_mem[rd_addr_reg]; // R17
                rd_addr_reg <= rd_addr_reg + 1'b1;
            end
        end
    end

    // ****************************************
    // measurement
    // ****************************************
    assign meas_start = par_wr && cmd_reg == `OP_MEASURE && idx_reg == 4'h0 && rx_byte[0]; // R7

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            meas_param_reg <= `MEAS_DEFAULT;
        else if (par_wr && cmd_reg == `OP_MEASURE && idx_reg == 4'h0)
            meas_param_reg <= rx_byte;
    end

    always_comb
    begin
        case (rx_byte[5:4])
            2'b00: meas_load = MEAS0_CYC; // R3
            2'b01: meas_load = MEAS1_CYC;
            2'b10: meas_load = MEAS2_CYC;
            default: meas_load = MEAS3_CYC;
        endcase
    end

    countdown_timer #(.W(32)) u_meas (
        .clk(clk),
        .rst_n(rst_n),
        .start(meas_start),
        .load(meas_load),
        .tick(1'b1),
        .busy(meas_busy)
    );

    assign measure_active = meas_busy;
    assign all_gates_on = meas_busy & meas_param_reg[3]; // R4
    assign measure_source_level = meas_busy & meas_param_reg[2]; // R5
    assign measure_result_path = meas_param_reg[1]; // R6

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_busy_d_reg <= 1'b0;
            measured_vcom_code <= 6'h00;
        end
        else
        begin
            meas_busy_d_reg <= meas_busy;
            if (meas_busy_d_reg && !meas_busy && !meas_param_reg[1])
                measured_vcom_code <= measured_code_in; // R6
        end
    end

    // ****************************************
    // vcom dc, window, partial mode
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            vcom_dc_code <= 6'h00;
        else if (par_wr && cmd_reg == `OP_VCOM_DC && idx_reg == 4'h0)
            vcom_dc_code <= (rx_byte[5:0] > `VCOM_DC_MAX) ? `VCOM_DC_MAX : rx_byte[5:0]; // R9
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            horiz_window_start <= 6'h00;
            horiz_window_end <= 6'h00;
            vert_window_start <= 9'h000;
            vert_window_end <= 9'h000;
            window_scan_option <= `WINDOW_SCAN_DEFAULT;
        end
        else if (par_wr && cmd_reg == `OP_WINDOW)
        begin
            case (idx_reg) // R10
                4'h0: horiz_window_start[5] <= rx_byte[0];
                4'h1: horiz_window_start[4:0] <= rx_byte[7:3];
                4'h2: horiz_window_end[5] <= rx_byte[0];
                4'h3: horiz_window_end[4:0] <= rx_byte[7:3];
                4'h4: vert_window_start[8] <= rx_byte[0];
                4'h5: vert_window_start[7:0] <= rx_byte;
                4'h6: vert_window_end[8] <= rx_byte[0];
                4'h7: vert_window_end[7:0] <= rx_byte;
                4'h8: window_scan_option <= rx_byte[0]; // R12
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            partial_active_flag <= 1'b0;
        else if (cmd_start && rx_byte == `OP_PART_IN)
            partial_active_flag <= 1'b1; // R13
        else if (cmd_start && rx_byte == `OP_PART_OUT)
            partial_active_flag <= 1'b0; // R14
    end

    // ****************************************
    // otp program mode and programming
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            program_mode <= 1'b0;
        else if (par_wr && cmd_reg == `OP_PROG_MODE && idx_reg == 4'h0 && rx_byte == `PROG_KEY)
            program_mode <= 1'b1; // R15
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wr_addr_reg <= '0;
        else if (par_wr && cmd_reg == `OP_PROG_MODE && program_mode && idx_reg != 4'h0)
            wr_addr_reg <= wr_addr_reg + 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (par_wr && cmd_reg == `OP_PROG_MODE && program_mode && idx_reg != 4'h0)
            otp_mem[wr_addr_reg] <= rx_byte;
    end

    assign prog_start = cmd_start && rx_byte == `OP_PROG_START && program_mode; // R16

    countdown_timer #(.W(32)) u_prog (
        .clk(clk),
        .rst_n(rst_n),
        .start(prog_start),
        .load(PROG_CYC),
        .tick(1'b1),
        .busy(prog_busy)
    );

    assign busy_n = ~(prog_busy | meas_busy); // R16

    // ****************************************
    // cascade, temperature, saving, supply
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cascade_en_reg <= 1'b0;
            fixed_temperature_select <= 1'b0;
            vcom_saving_width <= 4'h0;
            source_saving_width <= 4'h0;
            forced_temp_reg <= 8'h00;
            {supply_or_break_select, low_supply_threshold} <= `LOW_SUPPLY_DEFAULT;
        end
        else if (par_wr && idx_reg == 4'h0)
        begin
            case (cmd_reg)
                `OP_CASCADE: {fixed_temperature_select, cascade_en_reg} <= rx_byte[1:0]; // R19
                `OP_POWER_SAVE: {vcom_saving_width, source_saving_width} <= rx_byte; // R20
                `OP_FORCE_TEMP: forced_temp_reg <= rx_byte; // R21
                `OP_LOW_SUPPLY: {supply_or_break_select, low_supply_threshold} <= rx_byte[2:0]; // R22
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cascade_div_reg <= 1'b0;
            temperature_value <= 8'h00;
        end
        else
        begin
            cascade_div_reg <= cascade_en_reg ? ~cascade_div_reg : 1'b0; // R18
            temperature_value <= fixed_temperature_select ? forced_temp_reg // R19
                : sensor_temperature;
        end
    end

    assign cascade_clock_pin = cascade_div_reg;

    countdown_timer #(.W(32)) u_vsave (
        .clk(clk),
        .rst_n(rst_n),
        .start(polarity_reversal),
        .load({28'h0, vcom_saving_width}),
        .tick(line_tick),
        .busy(vcom_saving_active)
    );

    countdown_timer #(.W(32)) u_ssave (
        .clk(clk),
        .rst_n(rst_n),
        .start(polarity_reversal),
        .load(32'(source_saving_width) * 32'(`SRC_SAVE_UNIT_CYC)), // R20
        .tick(1'b1),
        .busy(source_saving_active)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_flags;
        cmd_start && rx_byte == `OP_FLAGS |=> tx_load_reg && tx_data_reg == $past(flag_byte);
    endproperty
    a_flags: assert property (p_flags) else $error("flag byte wrong"); // R2

    property p_rev;
        cmd_start && rx_byte == `OP_REVISION |=> tx_data_reg == $past(first_byte);
    endproperty
    a_rev: assert property (p_rev) else $error("revision byte wrong"); // R1

    property p_meas;
        meas_start |=> (!busy_n && measure_active) [*2];
    endproperty
    a_meas: assert property (p_meas) else $error("measurement did not start"); // R7

    property p_gates;
        measure_active && meas_param_reg[3] |-> all_gates_on && !busy_n;
    endproperty
    a_gates: assert property (p_gates) else $error("gates not held on"); // R4

    property p_vdc;
        par_wr && cmd_reg == `OP_VCOM_DC && rx_byte[5:0] > `VCOM_DC_MAX
            |=> vcom_dc_code == `VCOM_DC_MAX;
    endproperty
    a_vdc: assert property (p_vdc) else $error("vcom dc not saturated"); // R9

    property p_part;
        cmd_start && rx_byte == `OP_PART_IN |=> partial_active_flag && flag_byte[6];
    endproperty
    a_part: assert property (p_part) else $error("partial mode not entered"); // R13

    property p_pgm;
        program_mode |=> program_mode;
    endproperty
    a_pgm: assert property (p_pgm) else $error("program mode left"); // R15

    property p_cas;
        cascade_en_reg && $past(cascade_en_reg) |=> cascade_clock_pin != $past(cascade_clock_pin);
    endproperty
    a_cas: assert property (p_cas) else $error("cascade clock not toggling"); // R18

    property p_save;
        polarity_reversal |=> source_saving_active == |$past(source_saving_width);
    endproperty
    a_save: assert property (p_save) else $error("source saving not started"); // R20
endmodule

// ---- shared/epaper_cmd_defs.svh ----
// constants of the panel driver command decoder: opcodes, fields, defaults, timing
// assumes a 25 MHz core clock and a three-wire serial link with a data/command select
`ifndef EPAPER_CMD_DEFS_SVH
`define EPAPER_CMD_DEFS_SVH
// Functional notes
// R1: revision read returns one byte from OTP location one.
// R2: flag read returns partial, sensor error, sensor idle, frame, on, off, not-busy.
// R3: measurement duration code selects 3, 5, 8 or 10 seconds.
// R4: all-gates-on bit holds every gate on during measurement.
// R5: source outputs drive 0V or positive rail during measurement per bit.
// R6: result-path bit selects digital read or analog output of result.
// R7: writing bit0 one starts one measurement; parameter default 10h.
// R8: value read returns measured code in low six bits.
// R9: VCOM DC code stored, codes above 3Ah saturate at 3Ah.
// R10: partial window takes nine parameter bytes in fixed order.
// R11: host keeps window values in range, end above start.
// R12: scan option zero scans inside window only, one scans everywhere.
// R13: partial-in opcode enters partial mode.
// R14: partial-out opcode returns to normal mode.
// R15: program-mode opcode with key A5h enters program mode until reset.
// R16: activate-program runs programming, busy held until done.
// R17: OTP readback returns dummy byte then ascending bytes from zero.
// R18: cascade bit0 drives clock on cascade pin, else pin low.
// R19: cascade bit1 takes temperature from the forced byte.
// R20: polarity reversal applies VCOM and source saving widths.
// R21: force-temperature stores one eight-bit temperature value.
// R22: low-supply parameter sets threshold and detect or break select; default 03h.
// R23: opcode sent with select low, data with select high; low byte restarts.
// R24: host issues no command while busy.
`define OP_REVISION 8'h70
`define OP_FLAGS 8'h71
`define OP_MEASURE 8'h80
`define OP_VCOM_VALUE 8'h81
`define OP_VCOM_DC 8'h82
`define OP_WINDOW 8'h90
`define OP_PART_IN 8'h91
`define OP_PART_OUT 8'h92
`define OP_PROG_MODE 8'hA0
`define OP_PROG_START 8'hA1
`define OP_OTP_READ 8'hA2
`define OP_CASCADE 8'hE0
`define OP_POWER_SAVE 8'hE3
`define OP_LOW_SUPPLY 8'hE4
`define OP_FORCE_TEMP 8'hE5
`define PROG_KEY 8'hA5
`define REV_ADDR 16'h0001
`define MEAS_DEFAULT 8'h10
`define WINDOW_SCAN_DEFAULT 1'b1
`define LOW_SUPPLY_DEFAULT 3'h3
`define VCOM_DC_MAX 6'h3A
`define CLK_HZ 25000000
`define CLK_PERIOD_NS 40
`define MEAS_T0_S 3
`define MEAS_T1_S 5
`define MEAS_T2_S 8
`define MEAS_T3_S 10
`define SRC_SAVE_UNIT_NS 660
`define SRC_SAVE_UNIT_CYC ((`SRC_SAVE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_DEFAULT_CYC 1000
`endif

// ---- shared/epaper_cmd_pkg.sv ----
// types of the panel driver command decoder
// assumes nothing beyond the defines header
package epaper_cmd_pkg;
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_PARAM = 2'b01,
        ST_READ = 2'b10
    } cmd_state_e;
    typedef logic [7:0] byte_t;
endpackage

// ---- hw/countdown_timer.sv ----
// countdown timer: busy while the loaded count runs down on ticks
// assumes start and tick come from logic on the same clock
`timescale 1ns/10ps
module countdown_timer #(
    parameter int W = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic [W-1:0] load,
    input wire logic tick,
    // status
    output logic busy
);
    logic [W-1:0] count_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_reg <= '0;
        else if (start)
            count_reg <= load;
        else if (tick && count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    assign busy = (count_reg != '0);
endmodule

// ---- hw/spi3_byte_link.sv ----
// three-wire serial link: byte receive and byte send, msb first
// assumes pins are asynchronous to clk; sclk far slower than clk
`timescale 1ns/10ps
module spi3_byte_link (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic csb_n,
    input wire logic sclk,
    input wire logic sda_in,
    input wire logic dc,
    output logic sda_out,
    output logic sda_oe,
    // byte side
    input wire logic tx_mode,
    input wire logic tx_load,
    input wire logic [7:0] tx_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_is_data,
    output logic tx_next
);
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic sclk_d_reg;
    logic [2:0] bit_reg;
    logic [7:0] in_reg;
    logic [7:0] out_reg;
    logic cs_act;
    logic rise;
    logic fall;
    logic tx_dir;

    // ****************************************
    // pin synchroniser
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= 4'h1;
            s2_reg <= 4'h1;
            sclk_d_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= {dc, sda_in, sclk, csb_n};
            s2_reg <= s1_reg;
            sclk_d_reg <= s2_reg[1];
        end
    end

    assign cs_act = ~s2_reg[0];
    assign rise = s2_reg[1] & ~sclk_d_reg;
    assign fall = ~s2_reg[1] & sclk_d_reg;
    assign tx_dir = tx_mode & s2_reg[3];

    // ****************************************
    // bit counting and receive
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_reg <= 3'h0;
            in_reg <= 8'h00;
            rx_byte <= 8'h00;
            rx_valid <= 1'b0;
            rx_is_data <= 1'b0;
            tx_next <= 1'b0;
        end
        else
        begin
            rx_valid <= 1'b0;
            tx_next <= 1'b0;
            if (!cs_act)
                bit_reg <= 3'h0;
            else if (rise)
            begin
                bit_reg <= bit_reg + 3'h1;
                in_reg <= {in_reg[6:0], s2_reg[2]};
                if (bit_reg == 3'h7)
                begin
                    tx_next <= tx_dir;
                    rx_valid <= ~tx_dir;
                    rx_byte <= {in_reg[6:0], s2_reg[2]};
                    rx_is_data <= s2_reg[3];
                end
            end
        end
    end

    // ****************************************
    // send, shifted on falling edges
    // ****************************************
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            out_reg <= 8'h00;
        else if (tx_load)
            out_reg <= tx_byte;
        else if (fall && cs_act && tx_dir && bit_reg != 3'h0)
            out_reg <= {out_reg[6:0], 1'b0};
    end

    assign sda_out = out_reg[7];
    assign sda_oe = tx_dir & cs_act;
endmodule

// ---- tb/host_model.sv ----
// host model: drives the three-wire link byte by byte
// assumes clk is the core clock; sclk half period 4 clk
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic clk,
    // link pins
    output logic csb_n,
    output logic sclk,
    output logic sda_in,
    output logic dc,
    input wire logic sda_out
);
    // ****
    // byte tasks
    // ****
    initial
        {csb_n, sclk, sda_in, dc} = 4'h8;
    // msb first, read bit taken at sclk rise
    task automatic xfer(input logic d, input logic [7:0] tx, output logic [7:0] rx);
        csb_n = 1'b0;
        dc = d;
        repeat (10) @(negedge clk);
        for (int i = 7; i >= 0; i--)
        begin
            sda_in = tx[i];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            rx[i] = sda_out;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
    endtask
    task automatic done();
        repeat (4) @(negedge clk);
        csb_n = 1'b1;
        sda_in = ~sda_in;
        repeat (4) @(negedge clk);
    endtask
endmodule

// ---- tb/tb_epaper_cmd_status_partial_otp.sv ----
// bench for the command decoder: host model on the link, random status
// assumes short measure and program counts set at the instance
`timescale 1ns/10ps
`include "epaper_cmd_defs.svh"
module tb_epaper_cmd_status_partial_otp
    import epaper_cmd_pkg::*;
;
    logic clk, rst_n, csb_n, sclk, sda_in, dc, sda_out, busy_n, a, polarity_reversal;
    logic line_tick, all_gates_on, measure_source_level, partial_active_flag, program_mode;
    logic window_scan_option, cascade_clock_pin, fixed_temperature_select;
    logic supply_or_break_select;
    logic [1:0] low_supply_threshold;
    logic [3:0] vcom_saving_width, source_saving_width;
    logic [4:0] st;
    logic [5:0] measured_code_in, vcom_dc_code, hs, he, horiz_window_start, horiz_window_end;
    logic [8:0] vert_window_start, vert_window_end, vs, ve;
    byte_t sensor_temperature, temperature_value, v, r, d0, d1;
    logic [23:0] q;
    logic [31:0] seed = 32'h0000F92B;
    int fails = 0, comparisons = 0, bcnt = 0;
    host_model host_u (.clk, .csb_n, .sclk, .sda_in, .dc, .sda_out);
    epaper_cmd_status_partial_otp #(.MEAS0_CYC(50), .MEAS1_CYC(60), .MEAS2_CYC(70),
        .MEAS3_CYC(80), .PROG_CYC(20)) dut_u (.clk, .rst_n, .csb_n, .sclk, .sda_in, .dc,
        .sda_out, .sda_oe(), .busy_n, .sensor_master_error(st[4]),
        .sensor_master_idle_n(st[3]), .frame_received(st[2]), .powered_on_flag(st[1]),
        .powered_off_flag(st[0]), .measured_code_in, .sensor_temperature, .polarity_reversal,
        .line_tick, .measure_active(), .all_gates_on, .measure_source_level,
        .measure_result_path(), .measured_vcom_code(), .vcom_dc_code, .partial_active_flag,
        .horiz_window_start, .horiz_window_end, .vert_window_start, .vert_window_end,
        .window_scan_option, .program_mode, .cascade_clock_pin, .fixed_temperature_select,
        .temperature_value, .vcom_saving_width, .source_saving_width,
        .vcom_saving_active(), .source_saving_active(), .low_supply_threshold,
        .supply_or_break_select);
    // ****
    // clock, random source, tasks
    // ****
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic byte_t flags(input logic p, input logic [4:0] s);
        return {1'b0, p, s, 1'b1};
    endfunction
    function automatic logic [5:0] vdc(input logic [5:0] c);
        return (c > `VCOM_DC_MAX) ? `VCOM_DC_MAX : c;
    endfunction
    always @(negedge clk)
    begin
        {polarity_reversal, line_tick, sensor_temperature} <= 10'(rnd());
        if (busy_n === 1'b0)
            bcnt <= bcnt + 1;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input byte_t op, input int n, input logic [71:0] p);
        host_u.xfer(1'b0, op, r);
        for (int k = n - 1; k >= 0; k--)
            host_u.xfer(1'b1, p[8*k+:8], r);
        host_u.done();
    endtask
    task automatic rd(input byte_t op, input int n);
        host_u.xfer(1'b0, op, r);
        for (int k = 0; k < n; k++)
        begin
            host_u.xfer(1'b1, 8'(rnd()), r);
            q = {q[15:0], r};
        end
        host_u.done();
    endtask
    task automatic hold();
        for (int k = 0; k < 300 && busy_n !== 1'b1; k++)
            @(negedge clk);
    endtask
    task automatic conclude();
        if (fails == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #1000000;
        fails++;
        conclude();
    end
    initial
    begin
        {rst_n, st, measured_code_in} = 12'h240;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk({window_scan_option, low_supply_threshold, busy_n}, 4'hF);
        rd(`OP_FLAGS, 1);
        chk(q[7:0], 8'h13);
        wr(`OP_PROG_START, 0, 0);
        chk(bcnt, 0);
        wr(`OP_VCOM_DC, 1, 8'h3B);
        chk(vcom_dc_code, 6'h3A);
        for (int i = 0; i < 4; i++)
        begin
            st = 5'(rnd());
            v = 8'(rnd());
            rd(`OP_FLAGS, 1);
            chk(q[7:0], flags(1'b0, st));
            wr(`OP_VCOM_DC, 1, v);
            chk(vcom_dc_code, vdc(v[5:0]));
            wr(`OP_POWER_SAVE, 1, v);
            chk({vcom_saving_width, source_saving_width}, v);
            wr(`OP_LOW_SUPPLY, 1, v);
            chk({supply_or_break_select, low_supply_threshold}, v[2:0]);
            wr(`OP_FORCE_TEMP, 1, v);
            wr(`OP_CASCADE, 1, v);
            a = cascade_clock_pin;
            @(negedge clk);
            chk({fixed_temperature_select, a ^ cascade_clock_pin}, v[1:0]);
            chk(temperature_value, v[1] ? v : sensor_temperature);
            hs = 6'(rnd() % 49);
            he = 6'(hs + 1 + rnd() % (49 - hs));
            vs = 9'(rnd() % 299);
            ve = 9'(vs + 1 + rnd() % (299 - vs));
            wr(`OP_WINDOW, 9, {7'h00, hs, 3'h0, 7'h00, he, 3'h7, 7'h00, vs, 7'h00, ve, 7'h00, v[2]});
            chk({horiz_window_start, horiz_window_end, vert_window_start}, {hs, he, vs});
            chk({vert_window_end, window_scan_option}, {ve, v[2]});
        end
        wr(`OP_PART_IN, 0, 0);
        rd(`OP_FLAGS, 1);
        chk({partial_active_flag, q[7:0]}, {1'b1, flags(1'b1, st)});
        wr(`OP_PART_OUT, 0, 0);
        chk(partial_active_flag, 0);
        for (int d = 0; d < 4; d++)
        begin
            v = {2'h0, 2'(d), 2'(rnd()), 2'h1};
            measured_code_in = 6'(rnd());
            bcnt = 0;
            wr(`OP_MEASURE, 1, v);
            chk({all_gates_on, measure_source_level}, v[3:2]);
            hold();
            chk(bcnt, 50 + 10 * d);
            rd(`OP_VCOM_VALUE, 1);
            chk(q[7:0], {2'h0, measured_code_in});
        end
        bcnt = 0;
        wr(`OP_MEASURE, 1, 8'h3E);
        chk({bcnt, all_gates_on}, 0);
        d0 = 8'(rnd());
        d1 = 8'(rnd());
        wr(`OP_PROG_MODE, 3, {`PROG_KEY, d0, d1});
        chk(program_mode, 1);
        wr(`OP_PROG_START, 0, 0);
        hold();
        chk(bcnt, 20);
        rd(`OP_OTP_READ, 3);
        chk(q, {8'h00, d0, d1});
        rd(`OP_REVISION, 1);
        chk(q[7:0], d1);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        chk(program_mode, 0);
        conclude();
    end
endmodule
